// ### pkg/crx_map.svh
// Constants of the carrier-sense frame receiver: sizes, CRC values, limits.
// Assumes inclusion by name from the package and the design files.
`ifndef CRX_MAP_SVH
`define CRX_MAP_SVH

`define CRX_ADDR_W       48
`define CRX_TYPE_W       16
`define CRX_OCT_W        11
`define CRX_MIN_OCTETS   11'h040
`define CRX_MAX_OCTETS   11'h5EE
`define CRX_HDR_OCTETS   11'h00E
`define CRX_FCS_OCTETS   11'h004
`define CRX_STAGE_OCTETS 11'h040
`define CRX_DEST_END     11'h006
`define CRX_SRC_END      11'h00C
`define CRX_TYPE_END     11'h00E
`define CRX_CRC_POLY     32'hEDB88320
`define CRX_CRC_INIT     32'hFFFFFFFF
`define CRX_CRC_RESIDUE  32'hDEBB20E3
`define CRX_BCAST_ADDR   48'hFFFFFFFFFFFF
`define CRX_MC_ENTRIES   4
`define CRX_MC_IDX_W     2
`define CRX_FIFO_DEPTH   16
`define CRX_FIFO_WIDTH   8

`endif

// ### pkg/crx_pkg.sv
// Types shared by the frame receiver and its client-facing ports.
// Assumes crx_map.svh is on the include path.
`include "crx_map.svh"

package crx_pkg;

	typedef enum logic [1:0] {
		CRX_ST_WAIT_IDLE = 2'h0,
		CRX_ST_IDLE      = 2'h1,
		CRX_ST_RECV      = 2'h2,
		CRX_ST_DRAIN     = 2'h3
	} crx_state_e;

	typedef enum logic [1:0] {
		CRX_RS_OK        = 2'h0,
		CRX_RS_FCS_ERR   = 2'h1,
		CRX_RS_ALIGN_ERR = 2'h2
	} crx_status_e;

	typedef struct packed {
		logic                        wr;
		logic [`CRX_MC_IDX_W-1:0]    idx;
		logic [`CRX_ADDR_W-1:0]      addr;
		logic                        en;
	} crx_mc_cmd_s;

	typedef struct packed {
		logic [`CRX_ADDR_W-1:0]      dest;
		logic [`CRX_ADDR_W-1:0]      src;
		logic [`CRX_TYPE_W-1:0]      etype;
		crx_status_e                 status;
		logic                        oversize;
		logic [`CRX_OCT_W-1:0]       octets;
	} crx_result_s;

endpackage

// ### design/crx_crc.sv
// Octet-wide CRC-32 register, least significant bit of each octet first.
// Assumes clear and enable come from logic on the same clock.
`timescale 1ns/10ps
`include "crx_map.svh"

module crx_crc
	import crx_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	input  wire logic        clr,
	input  wire logic        en,
	input  wire logic [7:0]  octet,
	output logic      [31:0] crc
);

	logic [31:0] crc_d;
	logic [31:0] crc_q;

	// ----------------------------------------------------------------
	// Next value.
	// ----------------------------------------------------------------
	always_comb begin
		logic [31:0] c;
		c = crc_q;
		if (clr) begin
			c = `CRX_CRC_INIT;
		end else if (en) begin
			for (int i = 0; i < 8; i++) begin
				if (c[0] ^ octet[i]) begin
					c = (c >> 1) ^ `CRX_CRC_POLY;
				end else begin
					c = c >> 1;
				end
			end
		end
		crc_d = c;
	end

	// ----------------------------------------------------------------
	// Register.
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			crc_q <= `CRX_CRC_INIT;
		end else begin
			crc_q <= crc_d;
		end
	end

	assign crc = crc_q;

endmodule

// ### design/crx_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
// Assumes both sides run on ref_clk.
`timescale 1ns/10ps
`include "crx_map.svh"

module crx_fifo #(
	parameter int WIDTH = `CRX_FIFO_WIDTH,
	parameter int DEPTH = `CRX_FIFO_DEPTH
) (
	input  wire logic             ref_clk,
	input  wire logic             arst_n,
	input  wire logic             s_valid,
	output logic                  s_ready,
	input  wire logic [WIDTH-1:0] s_data,
	output logic                  m_valid,
	input  wire logic             m_ready,
	output logic      [WIDTH-1:0] m_data
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wp_q;
	logic [AW:0]      wp_d;
	logic [AW:0]      rp_q;
	logic [AW:0]      rp_d;
	logic             push;
	logic             pop;

	// ----------------------------------------------------------------
	// Pointers and flags.
	// ----------------------------------------------------------------
	always_comb begin
		m_valid = (wp_q != rp_q);
		s_ready = !((wp_q[AW] != rp_q[AW]) &&
			(wp_q[AW-1:0] == rp_q[AW-1:0]));
		push    = s_valid && s_ready;
		pop     = m_valid && m_ready;
		wp_d    = push ? wp_q + 1'b1 : wp_q;
		rp_d    = pop ? rp_q + 1'b1 : rp_q;
		m_data  = mem[rp_q[AW-1:0]];
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wp_q[AW-1:0]] <= s_data;
		end
	end

endmodule

// ### design/crx_rx.sv
// Receive side of a carrier-sense data link controller, one bit per clock.
// Assumes rx_bit and carrier_sense come from pins and are asynchronous.
`timescale 1ns/10ps
`include "crx_map.svh"

module crx_rx
	import crx_pkg::*;
(
	input  wire logic                   ref_clk,
	input  wire logic                   arst_n,
	input  wire logic                   rx_bit,
	input  wire logic                   carrier_sense,
	input  wire logic                   addr_load,
	input  wire logic [`CRX_ADDR_W-1:0] addr_value,
	input  wire crx_mc_cmd_s            mc_cmd,
	output logic                        data_valid,
	input  wire logic                   data_ready,
	output logic      [7:0]             data_octet,
	output logic                        result_valid,
	output crx_result_s                 result
);

	// ----------------------------------------------------------------
	// Pin synchronisers.
	// ----------------------------------------------------------------
	logic cs_s1, cs_s2;
	logic bit_s1, bit_s2;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cs_s1  <= 1'b1;
			cs_s2  <= 1'b1;
			bit_s1 <= 1'b0;
			bit_s2 <= 1'b0;
		end else begin
			cs_s1  <= carrier_sense;
			cs_s2  <= cs_s1;
			bit_s1 <= rx_bit;
			bit_s2 <= bit_s1;
		end
	end

	// ----------------------------------------------------------------
	// Address tables.
	// ----------------------------------------------------------------
	logic [`CRX_ADDR_W-1:0]     sta_q, sta_d;
	logic [`CRX_ADDR_W-1:0]     mc_addr_q [`CRX_MC_ENTRIES];
	logic [`CRX_ADDR_W-1:0]     mc_addr_d [`CRX_MC_ENTRIES];
	logic [`CRX_MC_ENTRIES-1:0] mc_on_q, mc_on_d;
	always_comb begin
		sta_d     = addr_load ? addr_value : sta_q;
		mc_addr_d = mc_addr_q;
		mc_on_d   = mc_on_q;
		if (mc_cmd.wr) begin
			mc_addr_d[mc_cmd.idx] = mc_cmd.addr;
			mc_on_d[mc_cmd.idx]   = mc_cmd.en;
		end
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sta_q     <= '0;
			mc_addr_q <= '{default: '0};
			mc_on_q   <= '0;
		end else begin
			sta_q     <= sta_d;
			mc_addr_q <= mc_addr_d;
			mc_on_q   <= mc_on_d;
		end
	end

	// ----------------------------------------------------------------
	// Receive state.
	// ----------------------------------------------------------------
	crx_state_e             st_q, st_d;
	logic [`CRX_OCT_W+2:0]  bits_q, bits_d;
	logic [`CRX_OCT_W-1:0]  oct_q, oct_d;
	logic [`CRX_OCT_W-1:0]  rd_q, rd_d;
	logic [7:0]             sh_q, sh_d;
	logic [`CRX_ADDR_W-1:0] dest_q, dest_d;
	logic [`CRX_ADDR_W-1:0] src_q, src_d;
	logic [`CRX_TYPE_W-1:0] type_q, type_d;
	logic                   mt_q, mt_d;
	logic                   over_q, over_d;
	logic                   long_q, long_d;
	logic                   res_v_q, res_v_d;
	crx_result_s            res_q, res_d;
	logic [7:0]             stage [64];
	logic [7:0]             octet_c;
	logic                   take, wr_en, crc_clr;
	logic                   push, push_rdy, hit;
	logic [2:0]             excess;
	logic [31:0]            crc;
	crx_crc u_crc (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.clr     (crc_clr),
		.en      (wr_en),
		.octet   (octet_c),
		.crc     (crc)
	);
	crx_fifo #(
		.WIDTH (`CRX_FIFO_WIDTH),
		.DEPTH (`CRX_FIFO_DEPTH)
	) u_fifo (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.s_valid (push),
		.s_ready (push_rdy),
		.s_data  (stage[rd_q[5:0]]),
		.m_valid (data_valid),
		.m_ready (data_ready),
		.m_data  (data_octet)
	);

	always_comb begin
		st_d    = st_q;
		bits_d  = bits_q;
		oct_d   = oct_q;
		rd_d    = rd_q;
		sh_d    = sh_q;
		dest_d  = dest_q;
		src_d   = src_q;
		type_d  = type_q;
		mt_d    = mt_q;
		over_d  = over_q;
		long_d  = long_q;
		res_v_d = 1'b0;
		res_d   = res_q;
		wr_en   = 1'b0;
		crc_clr = 1'b0;
		push    = 1'b0;
		octet_c = {bit_s2, sh_q[7:1]};
		excess  = bits_q[2:0];
		hit     = 1'b0;
		take    = cs_s2 && (st_q == CRX_ST_IDLE || st_q == CRX_ST_RECV);
		unique case (st_q)
			CRX_ST_WAIT_IDLE: begin
				if (!cs_s2) begin
					st_d = CRX_ST_IDLE;
				end
			end
			CRX_ST_IDLE: begin
				bits_d  = '0;
				oct_d   = '0;
				rd_d    = `CRX_HDR_OCTETS;
				mt_d    = 1'b0;
				over_d  = 1'b0;
				long_d  = 1'b0;
				crc_clr = 1'b1;
				if (cs_s2) begin
					st_d = CRX_ST_RECV;
				end
			end
			CRX_ST_RECV: begin
				if (!cs_s2) begin
					if (oct_q < `CRX_MIN_OCTETS || !mt_q || over_q) begin
						st_d = CRX_ST_IDLE;
					end else begin
						st_d = CRX_ST_DRAIN;
					end
				end
				push = mt_q && !over_q && oct_q >= `CRX_MIN_OCTETS &&
					(rd_q + `CRX_FCS_OCTETS) < oct_q;
			end
			CRX_ST_DRAIN: begin
				push = (rd_q + `CRX_FCS_OCTETS) < oct_q;
				if (!push) begin
					st_d           = CRX_ST_IDLE;
					res_v_d        = 1'b1;
					res_d.dest     = dest_q;
					res_d.src      = src_q;
					res_d.etype    = type_q;
					res_d.oversize = long_q;
					res_d.octets   = oct_q;
					if (crc == `CRX_CRC_RESIDUE) begin
						res_d.status = CRX_RS_OK;
					end else if (excess != 3'h0) begin
						res_d.status = CRX_RS_ALIGN_ERR;
					end else begin
						res_d.status = CRX_RS_FCS_ERR;
					end
				end
			end
		endcase
		if (push && push_rdy) begin
			rd_d = rd_q + 1'b1;
		end
		if (take) begin
			if (oct_q < `CRX_MAX_OCTETS) begin
				sh_d   = octet_c;
				bits_d = (st_q == CRX_ST_IDLE) ? 14'h0001 : bits_q + 1'b1;
				if (st_q == CRX_ST_RECV && bits_q[2:0] == 3'h7) begin
					wr_en = 1'b1;
					oct_d = oct_q + 1'b1;
					if (oct_q < `CRX_DEST_END) begin
						dest_d = {dest_q[`CRX_ADDR_W-9:0], octet_c};
					end else if (oct_q < `CRX_SRC_END) begin
						src_d = {src_q[`CRX_ADDR_W-9:0], octet_c};
					end else if (oct_q < `CRX_TYPE_END) begin
						type_d = {type_q[`CRX_TYPE_W-9:0], octet_c};
					end
					if (oct_q == `CRX_DEST_END - 11'h001) begin
						hit = (dest_d == sta_q) ||
							(dest_d == `CRX_BCAST_ADDR);
						for (int i = 0; i < `CRX_MC_ENTRIES; i++) begin
							hit = hit || (mc_on_q[i] &&
								dest_d == mc_addr_q[i]);
						end
						mt_d = hit;
					end
					if (oct_q >= rd_q + `CRX_STAGE_OCTETS) begin
						over_d = 1'b1;
					end
				end
			end else begin
				long_d = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q    <= CRX_ST_WAIT_IDLE;
			bits_q  <= '0;
			oct_q   <= '0;
			rd_q    <= `CRX_HDR_OCTETS;
			sh_q    <= '0;
			dest_q  <= '0;
			src_q   <= '0;
			type_q  <= '0;
			mt_q    <= 1'b0;
			over_q  <= 1'b0;
			long_q  <= 1'b0;
			res_v_q <= 1'b0;
			res_q   <= '0;
		end else begin
			st_q    <= st_d;
			bits_q  <= bits_d;
			oct_q   <= oct_d;
			rd_q    <= rd_d;
			sh_q    <= sh_d;
			dest_q  <= dest_d;
			src_q   <= src_d;
			type_q  <= type_d;
			mt_q    <= mt_d;
			over_q  <= over_d;
			long_q  <= long_d;
			res_v_q <= res_v_d;
			res_q   <= res_d;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			stage[oct_q[5:0]] <= octet_c;
		end
	end

	assign result_valid = res_v_q;
	assign result       = res_q;

	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);
	sequence s_short_end;
		st_q == CRX_ST_RECV && !cs_s2 && oct_q < `CRX_MIN_OCTETS;
	endsequence
	sequence s_back_idle;
		st_q == CRX_ST_IDLE ##1 !res_v_q;
	endsequence
	property p_wait_idle;
		st_q == CRX_ST_WAIT_IDLE && cs_s2 |=> st_q == CRX_ST_WAIT_IDLE;
	endproperty
	a_wait_idle: assert property (p_wait_idle)
		else $error("frame recognised before carrier went idle");
	property p_end_on_cs;
		st_q == CRX_ST_RECV && !cs_s2 |=> st_q != CRX_ST_RECV;
	endproperty
	a_end_on_cs: assert property (p_end_on_cs)
		else $error("reception continued after carrier dropped");
	property p_fragment;
		s_short_end |=> s_back_idle;
	endproperty
	a_fragment: assert property (p_fragment)
		else $error("fragment produced a result");
	property p_min_len;
		res_v_q |-> res_q.octets >= `CRX_MIN_OCTETS;
	endproperty
	a_min_len: assert property (p_min_len)
		else $error("result for a frame under minimum length");
	property p_status;
		res_v_q |-> res_q.status inside {CRX_RS_OK, CRX_RS_FCS_ERR,
			CRX_RS_ALIGN_ERR};
	endproperty
	a_status: assert property (p_status)
		else $error("illegal receive status");
	property p_max_len;
		oct_q <= `CRX_MAX_OCTETS;
	endproperty
	a_max_len: assert property (p_max_len)
		else $error("octet count beyond maximum");
	property p_push_match;
		push |-> mt_q;
	endproperty
	a_push_match: assert property (p_push_match)
		else $error("data delivered for unmatched frame");
	property p_whole_octet;
		st_q == CRX_ST_RECV && take && bits_q[2:0] != 3'h7 |=> $stable(oct_q);
	endproperty
	a_whole_octet: assert property (p_whole_octet)
		else $error("octet counted before eight bits");

endmodule

// ### bench/crx_phy.sv
// Line-side model: sends octets least significant bit first under carrier.
// Assumes the bench calls put and then drain from its main sequence.
`timescale 1ns/10ps

module crx_phy (
	input  wire logic ref_clk,
	output logic      rx_bit,
	output logic      carrier_sense
);
	bit bq[$];

	initial begin
		rx_bit = 1'b0;
		carrier_sense = 1'b0;
	end

	// ----------------------------------------------------------------
	// Bit channel.
	// ----------------------------------------------------------------
	// Carrier frames the queued bits; outside a frame the data line toggles.
	always @(negedge ref_clk) begin
		if (bq.size() != 0) begin
			carrier_sense <= 1'b1;
			rx_bit <= bq.pop_front();
		end else begin
			carrier_sense <= 1'b0;
			rx_bit <= ~rx_bit;
		end
	end

	task automatic put(input byte unsigned f[$], input int xb);
		foreach (f[i])
			for (int k = 0; k < 8; k++)
				bq.push_back(f[i][k]);
		for (int k = 0; k < xb; k++)
			bq.push_back(k[0]);
	endtask

	task automatic drain();
		while (bq.size() != 0)
			@(posedge ref_clk);
		repeat (2) @(posedge ref_clk);
	endtask
endmodule

// ### bench/crx_rx_tb.sv
// Self-checking bench of the frame receiver with a line model and a client.
// Assumes crx_pkg and the design files are compiled before this file.
`timescale 1ns/10ps
`include "crx_map.svh"
`define CHK(what, e, g) begin n_tests++; if ((g) !== (e)) begin \
	err_total++; $display("wrong value %s expected %h seen %h", what, e, g); \
	end end

module crx_rx_tb
	import crx_pkg::*;
;
	logic              ref_clk;
	logic              arst_n;
	logic              addr_load;
	logic        [47:0] addr_value;
	crx_mc_cmd_s       mc_cmd;
	logic              data_valid;
	logic              data_ready;
	logic        [7:0] data_octet;
	logic              result_valid;
	crx_result_s       result;
	logic              rx_bit;
	logic              carrier_sense;
	logic              stall;
	int                err_total;
	int                n_tests;
	logic        [7:0] exp_dat[$];
	crx_result_s       exp_res[$];
	logic        [7:0] exp_o;
	crx_result_s       exp_r;
	logic        [47:0] station;
	logic        [47:0] mc_addr[4];

	crx_rx dut (.ref_clk(ref_clk), .arst_n(arst_n), .rx_bit(rx_bit),
		.carrier_sense(carrier_sense), .addr_load(addr_load),
		.addr_value(addr_value), .mc_cmd(mc_cmd), .data_valid(data_valid),
		.data_ready(data_ready), .data_octet(data_octet),
		.result_valid(result_valid), .result(result));
	crx_phy phy (.ref_clk(ref_clk), .rx_bit(rx_bit),
		.carrier_sense(carrier_sense));

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// ----------------------------------------------------------------
	// Helpers.
	// ----------------------------------------------------------------
	function automatic logic [31:0] crc_of(input byte unsigned f[$],
			input int n);
		logic [31:0] c;
		c = `CRX_CRC_INIT;
		for (int i = 0; i < n; i++)
			for (int k = 0; k < 8; k++)
				c = (c >> 1) ^ ((c[0] ^ f[i][k]) ? `CRX_CRC_POLY : 32'h0);
		return c;
	endfunction

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic mgmt(input bit ld, input logic [1:0] ix,
			input logic [47:0] a, input bit en);
		@(negedge ref_clk);
		addr_load = ld;
		addr_value = a;
		mc_cmd = '{wr: !ld, idx: ix, addr: a, en: en};
		@(negedge ref_clk);
		addr_load = 1'b0;
		mc_cmd.wr = 1'b0;
	endtask

	// Builds a frame, notes what the client should get, then sends it.
	task automatic frame(input logic [47:0] d, input int n, input int xb,
			input bit bad, input bit take);
		byte unsigned f[$];
		logic [31:0] c;
		crx_result_s r;
		int m;
		for (int i = 0; i < n; i++)
			f.push_back(i < 6 ? d[47-8*i -: 8] : 8'($urandom));
		c = ~crc_of(f, n - 4) ^ {31'h0, bad};
		for (int i = 0; i < 4; i++)
			f[n-4+i] = c[8*i +: 8];
		m = (n > 1518) ? 1518 : n;
		r.dest = d;
		r.src = {f[6], f[7], f[8], f[9], f[10], f[11]};
		r.etype = {f[12], f[13]};
		r.oversize = (n > 1518);
		r.octets = m[10:0];
		if (crc_of(f, m) === `CRX_CRC_RESIDUE)
			r.status = CRX_RS_OK;
		else if (xb != 0)
			r.status = CRX_RS_ALIGN_ERR;
		else
			r.status = CRX_RS_FCS_ERR;
		if (take) begin
			exp_res.push_back(r);
			for (int i = 14; i < m - 4; i++)
				exp_dat.push_back(f[i]);
		end
		phy.put(f, xb);
		phy.drain();
		repeat (150) @(posedge ref_clk);
	endtask

	// ----------------------------------------------------------------
	// Client side and result watcher.
	// ----------------------------------------------------------------
	always @(negedge ref_clk)
		data_ready <= !stall && ($urandom % 4 != 0);

	always @(posedge ref_clk) begin
		if (data_valid === 1'b1 && data_ready === 1'b1) begin
			if (exp_dat.size() == 0) begin
				`CHK("extra data", 1'b0, 1'b1)
			end else begin
				exp_o = exp_dat.pop_front();
				`CHK("data_octet", exp_o, data_octet)
			end
		end
		if (result_valid === 1'b1) begin
			if (exp_res.size() == 0) begin
				`CHK("extra result", 1'b0, 1'b1)
			end else begin
				exp_r = exp_res.pop_front();
				`CHK("result", exp_r, result)
			end
		end
	end

	initial begin
		repeat (40000) @(posedge ref_clk);
		err_total++;
		stop_test();
	end

	// ----------------------------------------------------------------
	// Main sequence.
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'hC56D));
		arst_n = 1'b0;
		addr_load = 1'b0;
		addr_value = '0;
		mc_cmd = '0;
		data_ready = 1'b0;
		stall = 1'b0;
		err_total = 0;
		n_tests = 0;
		station = {8'h02, 8'($urandom), 32'($urandom)};
		fork
			frame(`CRX_BCAST_ADDR, 64, 0, 0, 0);
			begin
				repeat (2) @(posedge ref_clk);
				`CHK("reset result_valid", 1'b0, result_valid)
				`CHK("reset data_valid", 1'b0, data_valid)
				repeat (2) @(posedge ref_clk);
				@(negedge ref_clk);
				arst_n = 1'b1;
			end
		join
		mgmt(1'b1, 2'h0, station, 1'b0);
		stall = 1'b1;
		fork
			frame(station, 64, 0, 0, 1);
			begin
				repeat (530) @(posedge ref_clk);
				stall = 1'b0;
			end
		join
		frame(`CRX_BCAST_ADDR, 70, 3, 0, 1);
		frame(station, 80, 5, 1, 1);
		frame(station, 72, 0, 1, 1);
		frame(station, 63, 0, 0, 0);
		frame(station ^ 48'h000000000100, 64, 0, 0, 0);
		for (int i = 0; i < 4; i++) begin
			mc_addr[i] = {7'($urandom), 1'b1, 40'($urandom)};
			mgmt(1'b0, i[1:0], mc_addr[i], 1'b1);
			frame(mc_addr[i], 64 + i, 0, 0, 1);
		end
		mgmt(1'b0, 2'h2, mc_addr[2], 1'b0);
		frame(mc_addr[2], 64, 0, 0, 0);
		frame(mc_addr[3], 64, 0, 0, 1);
		frame(`CRX_BCAST_ADDR, 1520, 0, 0, 1);
		repeat (300) @(posedge ref_clk);
		`CHK("results left", 0, exp_res.size())
		`CHK("data left", 0, exp_dat.size())
		stop_test();
	end
endmodule
